/* File: design/ddc_pkg.sv */
// Shared constants, register map, coefficient tables and carrier types for the filter back end.
// Function
// - A 66-tap sum-of-products filter follows the half-band decimator and works on its output.
// - Each coefficient of that filter is a fixed 21-bit signed constant.
// - The 66-tap filter does not decimate; one output leaves for each input taken.
// - The 66-tap coefficient set is symmetric, tap k equal to tap 65-k, from 383 out to 922060.
// - The 66-tap filter is active only while the half-band stage is active, else bypassed.
// - A zero in bit 0 of register 0x102 bypasses the 66-tap filter.
// - Bits 5 and 6 of register 0x100 choose realignment on every sync or first sync only.
// - An accepted sync restarts the half-band decimator at the programmed phase.
// - In-phase and quadrature paths pass through identical half-band and 66-tap filters.
// - When enabled, the final mixer moves the signal from dc to fs/8 and outputs real samples.
// - When the final mixer is bypassed, I and Q leave alternately on one output stream.
// - Bit 3 of register 0x103 makes the half-band start on the first or second sample.
// - The half-band stage is a symmetric 19-tap fixed filter decimating by two.
package ddc_pkg;

  localparam int DW = 16;
  localparam int CW = 21;
  localparam int AW = 48;
  localparam int HB_TAPS = 19;
  localparam int FIR_TAPS = 66;
  localparam int HB_SHIFT = 20;
  localparam int FIR_SHIFT = 21;
  localparam int IDX_W = 10;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] SYNC_CTRL_IDX = 10'h100;
  localparam logic [IDX_W-1:0] FIR_CTRL_IDX = 10'h102;
  localparam logic [IDX_W-1:0] HB_CTRL_IDX = 10'h103;
  localparam logic [IDX_W-1:0] MIX_CTRL_IDX = 10'h108;
  localparam logic [IDX_W-1:0] STATUS_IDX = 10'h109;

  localparam int SYNC_EVERY_BIT = 5;
  localparam int SYNC_FIRST_BIT = 6;
  localparam int FIR_EN_BIT = 0;
  localparam int HB_HIGHPASS_BIT = 1;
  localparam int HB_REVERSE_BIT = 2;
  localparam int HB_PHASE_BIT = 3;
  localparam int MIX_EN_BIT = 0;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_FIR_ACTIVE_BIT = 1;
  localparam int ST_DEC_SKIP_BIT = 2;
  localparam int ST_MIX_PH_LSB = 4;
  localparam int ST_SYNC_CNT_LSB = 8;

  localparam logic RST_SYNC_EVERY = 1'b0;
  localparam logic RST_SYNC_FIRST = 1'b0;
  localparam logic RST_FIR_EN = 1'b0;
  localparam logic RST_HB_HIGHPASS = 1'b0;
  localparam logic RST_HB_REVERSE = 1'b0;
  localparam logic RST_HB_PHASE = 1'b0;
  localparam logic RST_MIX_EN = 1'b0;

  localparam logic signed [AW-1:0] SAT_MAX = 48'sh0000_0000_7fff;
  localparam logic signed [AW-1:0] SAT_MIN = 48'shffff_ffff_8000;
  localparam logic [DW-1:0] DW_MAX = 16'h7fff;
  localparam logic [DW-1:0] DW_MIN = 16'h8000;

  typedef logic signed [CW-1:0] coef_t;

  // Half-band taps 0..9; tap 9 is the centre, odd taps below it are zero.
  localparam coef_t HB_COEF [(HB_TAPS + 1) / 2] = '{
    21'sd844, 21'sd0, -21'sd6189, 21'sd0, 21'sd25080, 21'sd0, -21'sd79170, 21'sd0,
    21'sd321584, 21'sd524287
  };

  // Taps 0..32 of the 66-tap filter; taps 33..65 mirror them.
  localparam coef_t FIR_COEF [FIR_TAPS / 2] = '{
    21'sd383, 21'sd1431, 21'sd1950, 21'sd96, -21'sd2661, -21'sd1750, 21'sd2476, 21'sd2388,
    -21'sd3867, -21'sd5150, 21'sd3788, 21'sd7513, -21'sd4511, -21'sd11914, 21'sd3650,
    21'sd16484, -21'sd2818, -21'sd23200, -21'sd48, 21'sd30748, 21'sd3976, -21'sd41019,
    -21'sd11147, 21'sd53608, 21'sd21818, -21'sd71611, -21'sd40300, 21'sd98830, 21'sd74264,
    -21'sd152696, -21'sd161248, 21'sd337056, 21'sd922060
  };

  typedef struct packed {
    logic valid;
    logic [DW-1:0] i;
    logic [DW-1:0] q;
  } iq_sample_t;

  typedef struct packed {
    logic valid;
    logic is_q;
    logic [DW-1:0] data;
  } out_sample_t;

  function automatic logic [DW-1:0] sat_dw(input logic signed [AW-1:0] v);
    if (v > SAT_MAX) begin
      return DW_MAX;
    end else if (v < SAT_MIN) begin
      return DW_MIN;
    end
    return v[DW-1:0];
  endfunction

  function automatic logic [DW-1:0] neg_dw(input logic [DW-1:0] x);
    if (x == DW_MIN) begin
      return DW_MAX;
    end
    return 16'h0000 - x;
  endfunction

endpackage

/* File: design/sym_fir.sv */
// Symmetric fixed-coefficient filter for one sample path with optional output gating.
`timescale 1ns/1ps
module sym_fir #(
  parameter int TAPS = 19,
  parameter int SHIFT = 20,
  parameter ddc_pkg::coef_t COEF [(TAPS + 1) / 2] = '{default: '0}
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  input wire logic [ddc_pkg::DW-1:0] in_data,
  input wire logic take,
  output logic out_valid,
  output logic [ddc_pkg::DW-1:0] out_data
);
  import ddc_pkg::*;

  typedef struct packed {
    logic [TAPS-1:0][DW-1:0] line;
    logic valid;
    logic [DW-1:0] data;
  } fir_state_t;

  fir_state_t q;
  fir_state_t d;

  always_comb begin
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] pre;
    d = q;
    acc = '0;
    pre = '0;
    d.valid = 1'b0;
    if (in_valid) begin
      d.line = {q.line[TAPS-2:0], in_data};
    end
    // Pre-add mirrored taps, then one product per pair.
    for (int k = 0; k < TAPS / 2; k++) begin
      pre = AW'($signed(d.line[k])) + AW'($signed(d.line[TAPS-1-k]));
      acc = acc + pre * AW'(COEF[k]);
    end
    // The middle index stays in range for an even tap count, where this branch is dead.
    if ((TAPS % 2) == 1) begin
      acc = acc + AW'($signed(d.line[(TAPS-1)/2])) * AW'(COEF[(TAPS-1)/2]);
    end
    if (in_valid && take) begin
      d.valid = 1'b1;
      d.data = sat_dw(acc >>> SHIFT);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_valid = q.valid;
  assign out_data = q.data;

endmodule // sym_fir

/* File: design/ddc_back_end.sv */
// Half-band decimator, 66-tap filter, fs/8 mixer and output interleave behind an AHB-Lite slave.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ddc_back_end (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_in,
  input wire ddc_pkg::iq_sample_t samp_in,
  output ddc_pkg::out_sample_t samp_out
);
  import ddc_pkg::*;

  typedef struct packed {
    logic sync_every;
    logic sync_first;
    logic fir_en;
    logic hb_highpass;
    logic hb_reverse;
    logic hb_phase;
    logic mix_en;
    logic armed;
    logic dec_skip;
    logic in_odd;
    logic [1:0] mix_ph;
    logic [7:0] sync_cnt;
    logic ap_valid;
    logic ap_write;
    logic [IDX_W-1:0] ap_idx;
    logic [31:0] rdata;
    logic byp_valid;
    logic [DW-1:0] byp_i;
    logic [DW-1:0] byp_q;
    logic [DW-1:0] held_q;
    logic q_pending;
    out_sample_t out;
  } state_t;

  state_t q;
  state_t d;

  logic hb_active;
  logic fir_active;
  logic accept;
  logic emit;
  logic [DW-1:0] pre_i;
  logic [DW-1:0] pre_q;
  logic hb_i_valid;
  logic hb_q_valid;
  logic [DW-1:0] hb_i;
  logic [DW-1:0] hb_q;
  logic fir_i_valid;
  logic fir_q_valid;
  logic [DW-1:0] fir_i;
  logic [DW-1:0] fir_q;
  logic sel_valid;
  logic [DW-1:0] sel_i;
  logic [DW-1:0] sel_q;

  // The half-band stage cannot be switched off.
  assign hb_active = 1'b1;
  assign fir_active = q.fir_en & hb_active;

  // Every-sync mode, or first-only mode with the arming still standing.
  assign accept = sync_in & (q.sync_every | (q.sync_first & q.armed));

  // A sync cycle restarts the count; phase 1 skips the first sample after it.
  assign emit = ~accept & ~q.dec_skip;

  // High-pass response by alternating sign; spectral reversal by negating Q.
  always_comb begin
    pre_i = samp_in.i;
    pre_q = samp_in.q;
    if (q.hb_highpass && q.in_odd) begin
      pre_i = neg_dw(samp_in.i);
      pre_q = neg_dw(samp_in.q);
    end
    if (q.hb_reverse) begin
      pre_q = neg_dw(pre_q);
    end
  end

  sym_fir #(.TAPS(HB_TAPS), .SHIFT(HB_SHIFT), .COEF(HB_COEF)) hb_i_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(samp_in.valid),
    .in_data(pre_i),
    .take(emit),
    .out_valid(hb_i_valid),
    .out_data(hb_i)
  );

  sym_fir #(.TAPS(HB_TAPS), .SHIFT(HB_SHIFT), .COEF(HB_COEF)) hb_q_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(samp_in.valid),
    .in_data(pre_q),
    .take(emit),
    .out_valid(hb_q_valid),
    .out_data(hb_q)
  );

  // The 66-tap filters only see samples while active, so a bypass saves toggling.
  sym_fir #(.TAPS(FIR_TAPS), .SHIFT(FIR_SHIFT), .COEF(FIR_COEF)) fir_i_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(hb_i_valid & fir_active),
    .in_data(hb_i),
    .take(1'b1),
    .out_valid(fir_i_valid),
    .out_data(fir_i)
  );

  sym_fir #(.TAPS(FIR_TAPS), .SHIFT(FIR_SHIFT), .COEF(FIR_COEF)) fir_q_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(hb_q_valid & fir_active),
    .in_data(hb_q),
    .take(1'b1),
    .out_valid(fir_q_valid),
    .out_data(fir_q)
  );

  // Both branches carry one register stage, so latency is the same either way.
  always_comb begin
    if (fir_active) begin
      sel_valid = fir_i_valid & fir_q_valid;
      sel_i = fir_i;
      sel_q = fir_q;
    end else begin
      sel_valid = q.byp_valid;
      sel_i = q.byp_i;
      sel_q = q.byp_q;
    end
  end

  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;

    // Data phase of a write captured in the previous cycle.
    if (q.ap_valid && q.ap_write) begin
      unique case (q.ap_idx)
        SYNC_CTRL_IDX: begin
          d.sync_every = hwdata[SYNC_EVERY_BIT];
          d.sync_first = hwdata[SYNC_FIRST_BIT];
        end
        FIR_CTRL_IDX: begin
          d.fir_en = hwdata[FIR_EN_BIT];
        end
        HB_CTRL_IDX: begin
          d.hb_highpass = hwdata[HB_HIGHPASS_BIT];
          d.hb_reverse = hwdata[HB_REVERSE_BIT];
          d.hb_phase = hwdata[HB_PHASE_BIT];
        end
        MIX_CTRL_IDX: begin
          d.mix_en = hwdata[MIX_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // Arming from a register write wins over a sync consumed in the same cycle.
    if (accept) begin
      d.armed = 1'b0;
      d.sync_cnt = q.sync_cnt + 8'h01;
    end
    if (q.ap_valid && q.ap_write && (q.ap_idx == SYNC_CTRL_IDX)) begin
      d.armed = 1'b1;
    end

    // Decimation phase: restart on sync, then alternate on each input sample.
    if (accept) begin
      d.dec_skip = q.hb_phase;
      d.in_odd = 1'b0;
      d.mix_ph = 2'b00;
    end else if (samp_in.valid) begin
      d.dec_skip = ~q.dec_skip;
      d.in_odd = ~q.in_odd;
    end

    // Bypass register mirrors the filter's one-cycle stage.
    d.byp_valid = hb_i_valid & hb_q_valid;
    d.byp_i = hb_i;
    d.byp_q = hb_q;

    // Output stage: real fs/8 output or I then Q interleave.
    d.out.valid = 1'b0;
    d.out.is_q = 1'b0;
    if (sel_valid) begin
      d.out.valid = 1'b1;
      if (q.mix_en) begin
        // Output rate is fs/2, so fs/8 is a quarter turn per sample.
        unique case (q.mix_ph)
          2'b00: d.out.data = sel_i;
          2'b01: d.out.data = neg_dw(sel_q);
          2'b10: d.out.data = neg_dw(sel_i);
          2'b11: d.out.data = sel_q;
        endcase
        d.mix_ph = q.mix_ph + 2'b01;
      end else begin
        d.out.data = sel_i;
        d.held_q = sel_q;
        d.q_pending = 1'b1;
      end
    end else if (q.q_pending) begin
      d.out.valid = 1'b1;
      d.out.is_q = 1'b1;
      d.out.data = q.held_q;
      d.q_pending = 1'b0;
    end

    // Address phase; read data is taken from the already-updated state.
    d.ap_valid = hsel & htrans[1] & hready;
    d.ap_write = hwrite;
    d.ap_idx = haddr[IDX_W+1:2];
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[IDX_W+1:2])
        SYNC_CTRL_IDX: begin
          d.rdata[SYNC_EVERY_BIT] = d.sync_every;
          d.rdata[SYNC_FIRST_BIT] = d.sync_first;
        end
        FIR_CTRL_IDX: begin
          d.rdata[FIR_EN_BIT] = d.fir_en;
        end
        HB_CTRL_IDX: begin
          d.rdata[HB_HIGHPASS_BIT] = d.hb_highpass;
          d.rdata[HB_REVERSE_BIT] = d.hb_reverse;
          d.rdata[HB_PHASE_BIT] = d.hb_phase;
        end
        MIX_CTRL_IDX: begin
          d.rdata[MIX_EN_BIT] = d.mix_en;
        end
        STATUS_IDX: begin
          d.rdata[ST_ARMED_BIT] = d.armed;
          d.rdata[ST_FIR_ACTIVE_BIT] = d.fir_en & hb_active;
          d.rdata[ST_DEC_SKIP_BIT] = d.dec_skip;
          d.rdata[ST_MIX_PH_LSB+1:ST_MIX_PH_LSB] = d.mix_ph;
          d.rdata[ST_SYNC_CNT_LSB+7:ST_SYNC_CNT_LSB] = d.sync_cnt;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.sync_every <= RST_SYNC_EVERY;
      q.sync_first <= RST_SYNC_FIRST;
      q.fir_en <= RST_FIR_EN;
      q.hb_highpass <= RST_HB_HIGHPASS;
      q.hb_reverse <= RST_HB_REVERSE;
      q.hb_phase <= RST_HB_PHASE;
      q.mix_en <= RST_MIX_EN;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign samp_out = q.out;

endmodule // ddc_back_end

/* File: verif/ddc_back_end_sva.sv */
// Concurrent checks on the bus and sample ports of the filter back end.
`timescale 1ns/1ps
module ddc_back_end_sva
  import ddc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic sync_in,
  input wire ddc_pkg::iq_sample_t samp_in,
  input wire ddc_pkg::out_sample_t samp_out
);
  logic wr_q, fir_q, rd;
  logic [IDX_W-1:0] widx_q, idx;
  assign idx = haddr[11:2];
  assign rd = hsel && htrans[1] && hready && !hwrite;
  // Shadow of the filter enable bit, taken in the data phase of each write to the filter control register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      widx_q <= '0;
      fir_q <= 1'b0;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      widx_q <= idx;
      if (wr_q && widx_q == FIR_CTRL_IDX) begin
        fir_q <= hwdata[FIR_EN_BIT];
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_unmapped_zero: assert property (rd && !(idx inside {10'h100, 10'h102, 10'h103, 10'h108,
    10'h109}) |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_sync_fields: assert property (rd && idx == SYNC_CTRL_IDX |=> (hrdata & ~32'h60) == 32'h0)
    else $error("sync control has stray bits");
  a_hb_fields: assert property (rd && idx == HB_CTRL_IDX |=> (hrdata & ~32'he) == 32'h0)
    else $error("half-band control has stray bits");
  a_fir_readback: assert property (rd && idx == FIR_CTRL_IDX |=> hrdata == {31'h0, fir_q})
    else $error("filter enable readback wrong");
  a_fir_status: assert property (rd && idx == STATUS_IDX |=> hrdata[ST_FIR_ACTIVE_BIT] == fir_q)
    else $error("filter active status wrong");
  a_q_after_i: assert property (samp_out.valid && samp_out.is_q |->
    $past(samp_out.valid) && !$past(samp_out.is_q)) else $error("Q without preceding I");
  a_out_latency: assert property (samp_out.valid && !samp_out.is_q |->
    $past(samp_in.valid, 3)) else $error("output without input three cycles before");
  a_q_latency: assert property (samp_out.valid && samp_out.is_q |->
    $past(samp_in.valid, 4)) else $error("Q output without matching input");
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
endmodule // ddc_back_end_sva

bind ddc_back_end ddc_back_end_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sync_in(sync_in), .samp_in(samp_in), .samp_out(samp_out));

/* File: verif/out_sink.sv */
// Downstream receiver that logs every output sample in arrival order.
`timescale 1ns/1ps
module out_sink
  import ddc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire ddc_pkg::out_sample_t samp
);
  out_sample_t log_q [1024];
  logic [31:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (samp.valid) begin
      log_q[cnt_q[9:0]] <= samp;
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule // out_sink

/* File: verif/testbench.sv */
// Self-checking bench for the filter back end: registers, sync and sample stream.
`timescale 1ns/1ps
module testbench;
  import ddc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sync_in, run;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [DW-1:0] si, sq;
  iq_sample_t samp_in = '0;
  out_sample_t samp_out;
  int bad_count, cmp_count, c0;
  logic [IDX_W-1:0] ra [5] = '{10'h100, 10'h102, 10'h103, 10'h108, 10'h101};
  logic [31:0] rb [5] = '{32'h60, 32'h1, 32'he, 32'h1, 32'h0};

  ddc_back_end i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sync_in(sync_in),
    .samp_in(samp_in), .samp_out(samp_out));
  out_sink i_sink (.hclk(hclk), .hresetn(hresetn), .samp(samp_out));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    samp_in <= '{valid: run, i: si, q: sq};
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 1000) begin
      bad_count++;
      end_sim();
    end
  endtask

  // One single AHB-Lite transfer, entered just after a rising edge.
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'b00};
    // Ready and read data are taken as they stand at the rising edge itself.
    while (!rdy) begin
      @(posedge hclk);
      rdy = hreadyout;
      guard(n);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy = 1'b0;
    while (!rdy) begin
      @(posedge hclk);
      rdy = hreadyout;
      r = hrdata;
      guard(n);
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic pulse();
    sync_in <= 1'b1;
    @(posedge hclk);
    sync_in <= 1'b0;
    @(posedge hclk);
  endtask

  // Flush with zeros, then a sync together with a dc step on both paths.
  task automatic stream(input logic fir, input logic mix, input logic ph);
    int n;
    out_sample_t e;
    logic [DW-1:0] ev [4];
    logic [3:0] eq;
    n = 0;
    if (mix) begin
      ev = '{16'h1000, 16'hf800, 16'hf000, 16'h0800};
    end else begin
      ev = '{16'h1000, 16'h0800, 16'h1000, 16'h0800};
    end
    eq = mix ? 4'b0000 : 4'b1010;
    wr(FIR_CTRL_IDX, {31'h0, fir});
    wr(MIX_CTRL_IDX, {31'h0, mix});
    wr(HB_CTRL_IDX, {28'h0, ph, 3'h0});
    wr(SYNC_CTRL_IDX, 32'h20);
    si <= 16'h0;
    sq <= 16'h0;
    run <= 1'b1;
    repeat (200) @(posedge hclk);
    run <= 1'b0;
    repeat (8) @(posedge hclk);
    c0 = i_sink.cnt_q;
    si <= 16'h1000;
    sq <= 16'h0800;
    run <= 1'b1;
    sync_in <= 1'b1;
    @(posedge hclk);
    sync_in <= 1'b0;
    @(negedge hclk);
    while (samp_out.valid !== 1'b1) begin
      guard(n);
      @(negedge hclk);
    end
    chk(32'(n), 32'(3 + ph));
    while (i_sink.cnt_q < c0 + 200) begin
      @(posedge hclk);
      guard(n);
    end
    e = i_sink.log_q[10'(c0 + (mix ? 12 : 24))];
    chk(32'(e.data == 16'h1000), 32'(!fir));
    for (int j = 0; j < 4; j++) begin
      e = i_sink.log_q[10'(c0 + 196 + j)];
      chk(32'({e.is_q, e.data}), 32'({eq[j], ev[j]}));
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    sync_in = 1'b0;
    run = 1'b0;
    si = '0;
    sq = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(STATUS_IDX, 32'h0);
    foreach (ra[j]) begin
      rdchk(ra[j], 32'h0);
      wr(ra[j], 32'hffffffff);
      rdchk(ra[j], rb[j]);
    end
    bus(1'b0, STATUS_IDX, 32'h0, rd);
    chk(32'(rd[ST_FIR_ACTIVE_BIT]), 32'h1);
    stream(1'b0, 1'b0, 1'b0);
    stream(1'b0, 1'b0, 1'b1);
    stream(1'b1, 1'b1, 1'b0);
    stream(1'b1, 1'b0, 1'b1);
    wr(SYNC_CTRL_IDX, 32'h40);
    bus(1'b0, STATUS_IDX, 32'h0, rd);
    chk(32'({rd[ST_ARMED_BIT], rd[15:8]}), 32'({1'b1, 8'h04}));
    pulse();
    bus(1'b0, STATUS_IDX, 32'h0, rd);
    chk(32'({rd[ST_ARMED_BIT], rd[15:8]}), 32'({1'b0, 8'h05}));
    pulse();
    bus(1'b0, STATUS_IDX, 32'h0, rd);
    chk(32'(rd[15:8]), 32'h05);
    wr(SYNC_CTRL_IDX, 32'h20);
    pulse();
    pulse();
    bus(1'b0, STATUS_IDX, 32'h0, rd);
    chk(32'(rd[15:8]), 32'h07);
    end_sim();
  end
endmodule // testbench
